// File: core/ir_cfg_pkg.sv
package ir_cfg_pkg;

    // register indices carried in the setup stage of the vendor requests
    localparam logic [7:0] IDX_MODE    = 8'h00;
    localparam logic [7:0] IDX_FRAMING = 8'h01;
    localparam logic [7:0] IDX_TRANSCEIVER_CONTROL    = 8'h02;
    localparam logic [7:0] IDX_SIP     = 8'h03;
    localparam logic [7:0] IDX_MINRX   = 8'h04;
    localparam logic [7:0] IDX_TX_WIDTH = 8'h05;

    // mode register fields kept by this block
    localparam int         MODE_RATE_LO   = 5;
    localparam int         MODE_RATE_HI   = 7;
    localparam int         MODE_SIP_REQ   = 13;
    localparam logic [2:0] MODE_RATE_RST  = 3'h1;

    // framing fields
    localparam int         FRM_START_EN   = 7;
    localparam int         FRM_GAP_LO     = 8;
    localparam int         FRM_GAP_EN     = 15;
    localparam int         FRM_VALUE_W    = 6;
    localparam logic [15:0] FRAMING_RST   = 16'h0000;

    // transceiver control fields
    localparam int         XC_PIN_A       = 0;
    localparam int         XC_FAST_SEL    = 1;
    localparam int         XC_SETUP       = 2;
    localparam int         XC_HS_INPUT    = 3;
    localparam int         XC_LED_LO      = 4;
    localparam int         XC_LED_HI      = 6;
    localparam int         XC_PIN_B       = 7;
    localparam int         XC_SD_A        = 8;
    localparam int         XC_SD_B        = 9;
    localparam int         XC_TX_INV      = 10;
    localparam int         XC_RX_INV      = 11;
    localparam int         XC_CODE_LO     = 12;
    localparam int         XC_RW_W        = 12;
    localparam logic [11:0] TRANSCEIVER_CONTROL_RW_RST   = 12'h100;
    localparam logic [3:0] EE_CODE_RST    = 4'h0;
    // transceiver types whose mode is latched from the transmit line
    localparam logic [3:0] CODE_LATCH_A   = 4'h0;
    localparam logic [3:0] CODE_LATCH_B   = 4'h1;

    // sip timing fields
    localparam int         SIP_ON_W       = 7;
    localparam int         SIP_OFF_W      = 9;
    localparam logic [6:0] SIP_ON_RST     = 7'h4c;
    localparam logic [8:0] SIP_OFF_RST    = 9'h154;

    localparam logic [15:0] WIDTH_RST     = 16'h0000;

    // 48 MHz reference derived from the 125 MHz clock by a fractional accumulator
    localparam logic [7:0] CLK_MHZ        = 8'h7d;
    localparam logic [7:0] SIP_REF_MHZ    = 8'h30;

    // mode latch strobe phase length
    localparam int         LATCH_NS       = 200;
    localparam int         CLK_PERIOD_PS  = 8000;
    localparam int         LATCH_CYCLES   = (LATCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int         BAUD_W         = 21;
    localparam logic [BAUD_W-1:0] BAUD_BPS [8] = '{
        21'h000960, 21'h002580, 21'h004b00, 21'h009600,
        21'h00e100, 21'h01c200, 21'h08ca00, 21'h119400
    };

    typedef enum logic [1:0] {LATCH_IDLE, LATCH_SET, LATCH_CLR} latch_e;
    typedef enum logic [1:0] {SIP_IDLE, SIP_HIGH, SIP_LOW} sip_e;

endpackage

// File: core/ir_port_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
module ir_port_config_registers
    import ir_cfg_pkg::*;
#(
    parameter logic [5:0]  DEF_START_FLAGS = 6'h0a,
    parameter logic [5:0]  DEF_GAP         = 6'h0a,
    parameter logic [15:0] DEF_MIN_RX      = 16'h0004,
    parameter logic [15:0] DEF_TX_PW       = 16'h000c
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_index,
    input  wire logic [15:0]       reg_wdata,
    output logic [15:0]            reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              eeprom_load,
    input  wire logic [3:0]        eeprom_code_in,
    input  wire logic              shutdown_req,
    input  wire logic              tx_data_in,
    input  wire logic              rx_fast_in,
    input  wire logic              rx_slow_in,
    output logic                   tx_out,
    output logic                   transceiver_cfg_pin_a,
    output logic                   transceiver_cfg_pin_b,
    output logic                   transceiver_fast_select,
    output logic                   config_mode,
    output logic [2:0]             led_current_level,
    output logic [BAUD_W-1:0]      baud_bps,
    output logic [5:0]             start_flag_count,
    output logic [5:0]             interframe_gap_setting,
    output logic [15:0]            min_receive_width,
    output logic [15:0]            transmit_pulse_width_value,
    output logic                   rx_data,
    output logic                   sip_active
);
    logic [2:0]        rate_field;
    logic              software_sip_request;
    logic [15:0]       framing;
    logic [XC_RW_W-1:0] transceiver_control;
    logic [3:0]        eeprom_transceiver_code;
    logic [15:0]       sip_timing;
    logic [15:0]       min_rx_reg;
    logic [15:0]       tx_pw_reg;
    logic              sip_req_d;
    logic [7:0]        ref_acc;
    logic              ref_tick;
    logic              sip_out;
    logic              sip_busy;
    latch_e            latch_state;
    logic [7:0]        latch_cnt;
    logic              rx_sel;
    logic              latching_type;
    logic [15:0]       next_rdata;

    wire wr_mode  = reg_wr && reg_index == IDX_MODE;
    wire wr_transceiver_control  = reg_wr && reg_index == IDX_TRANSCEIVER_CONTROL;

    // register writes, one word per request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rate_field           <= MODE_RATE_RST;
            software_sip_request <= 1'b0;
            framing              <= FRAMING_RST;
            transceiver_control                 <= TRANSCEIVER_CONTROL_RW_RST;
            sip_timing           <= {SIP_OFF_RST, SIP_ON_RST};
            min_rx_reg           <= WIDTH_RST;
            tx_pw_reg            <= WIDTH_RST;
        end else if (reg_wr) begin
            if (reg_index == IDX_MODE) begin
                rate_field           <= reg_wdata[MODE_RATE_HI:MODE_RATE_LO];
                software_sip_request <= reg_wdata[MODE_SIP_REQ];
            end else if (reg_index == IDX_FRAMING) begin
                framing <= reg_wdata;
            end else if (reg_index == IDX_TRANSCEIVER_CONTROL) begin
                transceiver_control <= reg_wdata[XC_RW_W-1:0];
            end else if (reg_index == IDX_SIP) begin
                sip_timing <= reg_wdata;
            end else if (reg_index == IDX_MINRX) begin
                min_rx_reg <= reg_wdata;
            end else if (reg_index == IDX_TX_WIDTH) begin
                tx_pw_reg <= reg_wdata;
            end
        end
    end

    // transceiver type code, loaded only from the eeprom
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            eeprom_transceiver_code <= EE_CODE_RST;
        end else if (eeprom_load) begin
            eeprom_transceiver_code <= eeprom_code_in;
        end
    end

    // read port: unmapped indices answer zero
    always_comb begin
        next_rdata = '0;
        if (reg_index == IDX_MODE) begin
            next_rdata[MODE_RATE_HI:MODE_RATE_LO] = rate_field;
            next_rdata[MODE_SIP_REQ]              = software_sip_request;
        end else if (reg_index == IDX_FRAMING) begin
            next_rdata = framing;
        end else if (reg_index == IDX_TRANSCEIVER_CONTROL) begin
            next_rdata = {eeprom_transceiver_code, transceiver_control};
        end else if (reg_index == IDX_SIP) begin
            next_rdata = sip_timing;
        end else if (reg_index == IDX_MINRX) begin
            next_rdata = min_rx_reg;
        end else if (reg_index == IDX_TX_WIDTH) begin
            next_rdata = tx_pw_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // decoded framing, timing and transceiver control values
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            baud_bps                   <= BAUD_BPS[MODE_RATE_RST];
            start_flag_count           <= DEF_START_FLAGS;
            interframe_gap_setting     <= DEF_GAP;
            min_receive_width          <= DEF_MIN_RX;
            transmit_pulse_width_value <= DEF_TX_PW;
            led_current_level          <= '0;
            config_mode                <= 1'b0;
            transceiver_fast_select    <= 1'b0;
        end else begin
            baud_bps <= BAUD_BPS[rate_field];
            start_flag_count <= framing[FRM_START_EN] ?
                framing[FRM_VALUE_W-1:0] : DEF_START_FLAGS;
            interframe_gap_setting <= framing[FRM_GAP_EN] ?
                framing[FRM_GAP_LO+FRM_VALUE_W-1:FRM_GAP_LO] : DEF_GAP;
            min_receive_width <= (min_rx_reg != '0) ? min_rx_reg : DEF_MIN_RX;
            transmit_pulse_width_value <= (tx_pw_reg != '0) ? tx_pw_reg : DEF_TX_PW;
            led_current_level <= transceiver_control[XC_LED_HI:XC_LED_LO];
            config_mode <= transceiver_control[XC_SETUP];
            transceiver_fast_select <= transceiver_control[XC_FAST_SEL];
        end
    end

    // 48 MHz enable from the 125 MHz clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ref_acc  <= '0;
            ref_tick <= 1'b0;
        end else if (ref_acc + SIP_REF_MHZ >= CLK_MHZ) begin
            ref_acc  <= ref_acc + SIP_REF_MHZ - CLK_MHZ;
            ref_tick <= 1'b1;
        end else begin
            ref_acc  <= ref_acc + SIP_REF_MHZ;
            ref_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sip_req_d <= 1'b0;
        end else begin
            sip_req_d <= software_sip_request;
        end
    end

    sip_pulse_gen u_sip (
        .clk       (clk),
        .rst_b     (rst_b),
        .start     (software_sip_request && !sip_req_d),
        .ref_tick  (ref_tick),
        .high_time (sip_timing[SIP_ON_W-1:0]),
        .low_time  (sip_timing[15:SIP_ON_W]),
        .sip_out   (sip_out),
        .busy      (sip_busy)
    );

    // mode latch strobe for transceivers that sample their mode on tx
    assign latching_type = (eeprom_transceiver_code == CODE_LATCH_A) ||
                           (eeprom_transceiver_code == CODE_LATCH_B);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            latch_state <= LATCH_IDLE;
            latch_cnt   <= '0;
        end else begin
            case (latch_state)
                LATCH_IDLE: begin
                    latch_cnt <= '0;
                    if (wr_transceiver_control && reg_wdata[XC_SETUP] && latching_type) begin
                        latch_state <= LATCH_SET;
                    end
                end
                LATCH_SET: begin
                    if (latch_cnt == 8'(LATCH_CYCLES - 1)) begin
                        latch_state <= LATCH_CLR;
                        latch_cnt   <= '0;
                    end else begin
                        latch_cnt <= latch_cnt + 8'h01;
                    end
                end
                LATCH_CLR: begin
                    if (latch_cnt == 8'(LATCH_CYCLES - 1)) begin
                        latch_state <= LATCH_IDLE;
                    end else begin
                        latch_cnt <= latch_cnt + 8'h01;
                    end
                end
                default: latch_state <= LATCH_IDLE;
            endcase
        end
    end

    // transceiver pins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            transceiver_cfg_pin_a <= TRANSCEIVER_CONTROL_RW_RST[XC_SD_A];
            transceiver_cfg_pin_b <= TRANSCEIVER_CONTROL_RW_RST[XC_SD_B];
            tx_out                <= 1'b0;
        end else begin
            if (shutdown_req) begin
                transceiver_cfg_pin_a <= transceiver_control[XC_SD_A];
                transceiver_cfg_pin_b <= transceiver_control[XC_SD_B];
            end else if (latch_state != LATCH_IDLE) begin
                transceiver_cfg_pin_a <= (latch_state == LATCH_SET);
                transceiver_cfg_pin_b <= transceiver_control[XC_PIN_B];
            end else begin
                transceiver_cfg_pin_a <= transceiver_control[XC_PIN_A];
                transceiver_cfg_pin_b <= transceiver_control[XC_PIN_B];
            end
            if (latch_state != LATCH_IDLE) begin
                tx_out <= transceiver_control[XC_FAST_SEL];
            end else begin
                tx_out <= (tx_data_in | sip_out) ^ transceiver_control[XC_TX_INV];
            end
        end
    end

    // receive path: pin select, polarity, noise filter
    assign rx_sel = (transceiver_control[XC_HS_INPUT] ? rx_fast_in : rx_slow_in)
                    ^ transceiver_control[XC_RX_INV];

    rx_pulse_filter #(
        .WIDTH_W (16)
    ) u_rx_filter (
        .clk       (clk),
        .rst_b     (rst_b),
        .din       (rx_sel),
        .min_width (min_receive_width),
        .dout      (rx_data)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sip_active <= 1'b0;
        end else begin
            sip_active <= sip_busy;
        end
    end

    baud_map_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_mode |=> ##1 baud_bps == BAUD_BPS[$past(reg_wdata[7:5], 2)])
        else $error("baud rate does not follow rate field");

    start_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 $past(framing[FRM_START_EN]) |->
            start_flag_count == $past(framing[5:0]))
        else $error("custom start flag count not applied");

    gap_default_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 !$past(framing[FRM_GAP_EN]) |-> interframe_gap_setting == DEF_GAP)
        else $error("built-in gap not used");

    shutdown_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
        shutdown_req |=> transceiver_cfg_pin_a == $past(transceiver_control[XC_SD_A]) &&
                         transceiver_cfg_pin_b == $past(transceiver_control[XC_SD_B]))
        else $error("shutdown values not on mode pins");

    ee_readonly_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_transceiver_control && !eeprom_load |=> $stable(eeprom_transceiver_code))
        else $error("eeprom code changed by a write");

    latch_strobe_a: assert property (@(posedge clk) disable iff (!rst_b)
        latch_state == LATCH_IDLE && wr_transceiver_control && reg_wdata[XC_SETUP] && latching_type
        && !shutdown_req |=> ##1 transceiver_cfg_pin_a && tx_out == transceiver_control[XC_FAST_SEL])
        else $error("mode latch strobe did not start");

    tx_invert_a: assert property (@(posedge clk) disable iff (!rst_b)
        latch_state == LATCH_IDLE |=>
            tx_out == (($past(tx_data_in) | $past(sip_out)) ^ $past(transceiver_control[XC_TX_INV])))
        else $error("transmit polarity wrong");

    min_width_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 $past(min_rx_reg) == 16'h0000 |-> min_receive_width == DEF_MIN_RX)
        else $error("built-in receive width not used");

    sip_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        software_sip_request && !sip_req_d && !sip_busy |=> ##1 sip_active)
        else $error("sip not started on request edge");

    led_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_transceiver_control |=> ##1 led_current_level == $past(reg_wdata[6:4], 2))
        else $error("led current not applied");
endmodule // ir_port_config_registers
`default_nettype wire

// File: core/rx_pulse_filter.sv
`timescale 1ns/1ps
`default_nettype none
module rx_pulse_filter #(
    parameter int WIDTH_W = 16
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               din,
    input  wire logic [WIDTH_W-1:0] min_width,
    output logic                    dout
);
    logic [WIDTH_W-1:0] run;

    // a level change passes only after holding for min_width cycles
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dout <= 1'b0;
            run  <= '0;
        end else if (din == dout) begin
            run <= '0;
        end else if (run + 1'b1 >= min_width) begin
            dout <= din;
            run  <= '0;
        end else begin
            run <= run + 1'b1;
        end
    end
endmodule // rx_pulse_filter
`default_nettype wire

// File: core/sip_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sip_pulse_gen
    import ir_cfg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 start,
    input  wire logic                 ref_tick,
    input  wire logic [SIP_ON_W-1:0]  high_time,
    input  wire logic [SIP_OFF_W-1:0] low_time,
    output logic                      sip_out,
    output logic                      busy
);
    sip_e               state;
    logic [SIP_OFF_W-1:0] ticks;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= SIP_IDLE;
            ticks <= '0;
        end else begin
            case (state)
                SIP_IDLE: begin
                    ticks <= '0;
                    if (start) begin
                        state <= SIP_HIGH;
                    end
                end
                SIP_HIGH: begin
                    if (ref_tick) begin
                        if (ticks + 9'h001 >= {2'b00, high_time}) begin
                            state <= SIP_LOW;
                            ticks <= '0;
                        end else begin
                            ticks <= ticks + 9'h001;
                        end
                    end
                end
                SIP_LOW: begin
                    if (ref_tick) begin
                        if (ticks + 9'h001 >= low_time) begin
                            state <= SIP_IDLE;
                            ticks <= '0;
                        end else begin
                            ticks <= ticks + 9'h001;
                        end
                    end
                end
                default: state <= SIP_IDLE;
            endcase
        end
    end

    assign sip_out = (state == SIP_HIGH);
    assign busy    = (state != SIP_IDLE);
endmodule // sip_pulse_gen
`default_nettype wire

// File: testbench/ir_port_config_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ir_port_config_registers_tb
    import ir_cfg_pkg::*;
;
    logic clk, rst_b, reg_wr, reg_rd, eeprom_load, shutdown_req, tx_data_in, light;
    logic rx_fast_in, rx_slow_in, tx_out, pin_a, pin_b, fast_sel, config_mode;
    logic reg_rvalid, rx_data, sip_active, latched_fast;
    logic [7:0]        reg_index;
    logic [15:0]       reg_wdata, reg_rdata, min_rx, tx_pw;
    logic [3:0]        eeprom_code_in;
    logic [2:0]        led;
    logic [5:0]        start_flags, gap;
    logic [BAUD_W-1:0] baud_bps;
    logic [20:0]       exp_bps [8] = '{21'h000960, 21'h002580, 21'h004b00, 21'h009600,
                                       21'h00e100, 21'h01c200, 21'h08ca00, 21'h119400};
    int error_cnt = 0, tests_run = 0, cyc = 0, rx_hi = 0;

    ir_port_config_registers ir_port_config_registers_i (
        .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .eeprom_load(eeprom_load), .eeprom_code_in(eeprom_code_in),
        .shutdown_req(shutdown_req), .tx_data_in(tx_data_in), .rx_fast_in(rx_fast_in),
        .rx_slow_in(rx_slow_in), .tx_out(tx_out), .transceiver_cfg_pin_a(pin_a),
        .transceiver_cfg_pin_b(pin_b), .transceiver_fast_select(fast_sel),
        .config_mode(config_mode), .led_current_level(led), .baud_bps(baud_bps),
        .start_flag_count(start_flags), .interframe_gap_setting(gap),
        .min_receive_width(min_rx), .transmit_pulse_width_value(tx_pw),
        .rx_data(rx_data), .sip_active(sip_active));

    ir_transceiver_model ir_transceiver_model_i (.tx_line(tx_out), .mode_a(pin_a),
        .fast_sel(fast_sel), .light(light), .rx_fast(rx_fast_in), .rx_slow(rx_slow_in),
        .latched_fast(latched_fast));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (rx_data === 1'b1) rx_hi++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // one word per request, index and data together
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_index <= idx;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // answer is checked just after the edge that samples the request; reg_rdata holds until the next read
    task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
        @(posedge clk);
        reg_rd    <= 1'b1;
        reg_index <= idx;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rvalid", 1, reg_rvalid);
        chk("reg_rdata", {16'h0, exp}, {16'h0, reg_rdata});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic hold(input logic v);
        @(posedge clk);
        light <= v;
        repeat (20) @(posedge clk);
        #1;
    endtask

    task automatic ld(input logic [3:0] code);
        @(posedge clk);
        eeprom_load    <= 1'b1;
        eeprom_code_in <= code;
        @(posedge clk);
        eeprom_load <= 1'b0;
    endtask

    // shutdown held so the pins show the reset shutdown values
    task automatic t_reset();
        shutdown_req <= 1'b1;
        rdchk(IDX_FRAMING, 16'h0000);
        rdchk(IDX_TRANSCEIVER_CONTROL, 16'h0100);
        rdchk(IDX_SIP, 16'haa4c);
        rdchk(IDX_MINRX, 16'h0000);
        rdchk(IDX_TX_WIDTH, 16'h0000);
        rdchk(IDX_MODE, 16'h0020);
        chk("pin_a", 1, pin_a);
        chk("pin_b", 0, pin_b);
        chk("baud reset", {11'h0, exp_bps[1]}, {11'h0, baud_bps});
        chk("flags gap reset", 12'h28a, {start_flags, gap});
        shutdown_req <= 1'b0;
    endtask

    // ir logic reset after changing marked bits restores defaults
    task automatic t_ir_reset();
        wr(IDX_FRAMING, 16'h8285);
        wr(IDX_MODE, 16'h00e0);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
    endtask

    task automatic t_rates();
        for (int r = 0; r < 8; r++) begin
            wr(IDX_MODE, {8'h00, r[2:0], 5'h00});
            settle();
            chk("baud_bps", {11'h0, exp_bps[r]}, {11'h0, baud_bps});
            rdchk(IDX_MODE, {8'h00, r[2:0], 5'h00});
        end
    endtask

    task automatic t_framing();
        wr(IDX_FRAMING, 16'h8285);
        settle();
        chk("start_flags", 5, start_flags);
        chk("gap", 2, gap);
        wr(IDX_FRAMING, 16'h0205);
        settle();
        chk("start_flags", 10, start_flags);
        chk("gap", 10, gap);
    endtask

    task automatic t_widths();
        wr(IDX_MINRX, 16'h0033);
        wr(IDX_TX_WIDTH, 16'h0000);
        settle();
        chk("min_rx", 16'h0033, min_rx);
        chk("tx_pw", 16'h000c, tx_pw);
        wr(IDX_MINRX, 16'h0000);
        wr(IDX_TX_WIDTH, 16'h0021);
        settle();
        chk("min_rx", 16'h0004, min_rx);
        chk("tx_pw", 16'h0021, tx_pw);
        wr(8'h09, 16'hffff);
        rdchk(8'h09, 16'h0000);
    endtask

    task automatic t_rx();
        int base;
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0000);
        wr(IDX_MINRX, 16'h0006);
        settle();
        base = rx_hi;
        @(posedge clk);
        light <= 1'b1;
        repeat (3) @(posedge clk);
        light <= 1'b0;
        repeat (20) @(posedge clk);
        chk("short pulse", 0, rx_hi - base);
        hold(1'b1);
        chk("rx slow", 1, rx_data);
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0008);
        hold(1'b1);
        chk("rx fast idle", 0, rx_data);
        wr(IDX_TRANSCEIVER_CONTROL, 16'h000a);
        hold(1'b1);
        chk("rx fast", 1, rx_data);
        hold(1'b0);
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0800);
        hold(1'b0);
        chk("rx inverted", 1, rx_data);
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0000);
        hold(1'b0);
        chk("rx plain", 0, rx_data);
    endtask

    task automatic t_transceiver_control();
        ld(4'h2);
        wr(IDX_TRANSCEIVER_CONTROL, 16'hfeff);
        settle();
        rdchk(IDX_TRANSCEIVER_CONTROL, 16'h2eff);
        chk("pins", 3'h7, {pin_a, pin_b, fast_sel});
        chk("config_mode", 1, config_mode);
        chk("led", 7, led);
        chk("tx inverted", 1, tx_out);
        shutdown_req <= 1'b1;
        settle();
        chk("shutdown pins", 2'b01, {pin_a, pin_b});
        shutdown_req <= 1'b0;
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0000);
        tx_data_in <= 1'b1;
        settle();
        chk("tx plain", 1, tx_out);
        chk("setup off", 4'h0, {config_mode, led});
        tx_data_in <= 1'b0;
    endtask

    task automatic t_sip();
        int hi, lo;
        wr(IDX_SIP, 16'h0c0c);
        for (int k = 0; k < 2; k++) begin
            hi = 0;
            lo = 0;
            wr(IDX_MODE, 16'h2020);
            repeat (150) begin
                @(posedge clk);
                #1;
                hi += (tx_out === 1'b1);
                lo += (sip_active === 1'b1 && tx_out === 1'b0);
            end
            // 12 and 24 ticks of 48 MHz, quantised to whole 125 MHz cycles
            chk("sip high ok", k == 0, hi >= 29 && hi <= 32);
            chk("sip low ok", k == 0, lo >= 60 && lo <= 63);
        end
        wr(IDX_MODE, 16'h0020);
    endtask

    task automatic t_latch();
        int hi = 0;
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0001);
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0000);
        settle();
        chk("latched pre", 0, latched_fast);
        ld(4'h0);
        wr(IDX_TRANSCEIVER_CONTROL, 16'h0006);
        repeat (80) begin
            @(posedge clk);
            #1;
            hi += (pin_a === 1'b1);
        end
        chk("strobe length", LATCH_CYCLES, hi);
        chk("latched fast", 1, latched_fast);
        chk("pin_a after", 0, pin_a);
    endtask

    initial begin
        {rst_b, reg_wr, reg_rd, eeprom_load, shutdown_req, tx_data_in, light} = '0;
        reg_index      = 8'h00;
        reg_wdata      = 16'h0000;
        eeprom_code_in = 4'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_rates();
        t_framing();
        t_ir_reset();
        t_widths();
        t_rx();
        t_transceiver_control();
        t_sip();
        t_latch();
        complete_run();
    end
endmodule // ir_port_config_registers_tb
`default_nettype wire

// File: testbench/ir_transceiver_model.sv
`timescale 1ns/1ps
`default_nettype none
module ir_transceiver_model (
    input  wire logic tx_line,
    input  wire logic mode_a,
    input  wire logic fast_sel,
    input  wire logic light,
    output logic      rx_fast,
    output logic      rx_slow,
    output logic      latched_fast
);
    initial latched_fast = 1'b0;
    // mode is captured from the transmit line as the strobe falls
    always @(negedge mode_a) latched_fast = tx_line;
    // fast output idles low unless fast mode is selected or latched
    assign rx_fast = (fast_sel | latched_fast) ? light : 1'b0;
    assign rx_slow = light;
endmodule // ir_transceiver_model
`default_nettype wire
